// ---- hw/flash_security_pkg.sv ----
// constants shared by the flash security gate and its permission checker
// assumes a 100 MHz core clock and a byte-addressed avalon-mm register bus
package flash_security_pkg;
  // register byte offsets
  localparam logic [4:0] SP_CTRL_OFS = 5'h00;
  localparam logic [4:0] SP_CMD_OFS = 5'h04;
  localparam logic [4:0] SP_STATUS_OFS = 5'h08;
  localparam logic [4:0] SEC_STORED_OFS = 5'h0c;
  localparam logic [4:0] SEC_ACTIVE_OFS = 5'h10;
  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  // command fields: address in low half, operation above it
  localparam int CMD_OP_LSB = 16;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OK_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_SUSPENDED_BIT = 3;
  localparam int ST_ACTIVE_BIT = 4;
  localparam int ST_SUBCLK_BIT = 5;
  // security flag positions
  localparam int SEC_CHIP_BIT = 0;
  localparam int SEC_BLOCK_BIT = 1;
  localparam int SEC_WRITE_BIT = 2;
  localparam int SEC_BOOT_BIT = 3;
  localparam logic [3:0] SEC_RESET = 4'h0;
  // boot cluster 0 address range
  localparam logic [15:0] BOOT0_FIRST = 16'h0000;
  localparam logic [15:0] BOOT0_LAST = 16'h0fff;
  // oscillator stop flag position in the oscillator mode register
  localparam int HS_OSC_STOP_BIT = 0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SP_OP_TIME_NS = 200;
  localparam int SP_OP_CYCLES = (SP_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // flash operations
  typedef enum logic [1:0] {
    OP_CHIP_ERASE = 2'b00,
    OP_BLOCK_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_SEC_SET = 2'b11
  } flash_op_t;
  // self-programming sequencer states
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_CHECK = 2'b01,
    SP_RUN = 2'b10
  } sp_state_t;
endpackage

// ---- hw/sec_permit_check.sv ----
// registered permission decision for one flash request
// assumes flags are the security settings valid for the current session
`timescale 1ns/1ps
module sec_permit_check
  import flash_security_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request
  input wire logic check_valid,
  input wire logic self_mode,
  input wire flash_op_t op,
  input wire logic [15:0] addr,
  input wire logic [3:0] flags,
  // decision, one cycle later
  output logic result_valid,
  output logic permit
);
  logic chip_p, blk_p, wr_p, boot_p, boot_hit, next_permit;
  assign chip_p = flags[SEC_CHIP_BIT];
  assign blk_p = flags[SEC_BLOCK_BIT];
  assign wr_p = flags[SEC_WRITE_BIT];
  assign boot_p = flags[SEC_BOOT_BIT];
  assign boot_hit = (addr >= BOOT0_FIRST) && (addr <= BOOT0_LAST);

  // decision table per mode and operation
  always_comb begin
    next_permit = 1'b0;
    if (self_mode) begin
      // chip, block and write prohibitions do not apply here
      case (op)
        OP_BLOCK_ERASE: next_permit = !(boot_p && boot_hit);
        OP_WRITE: next_permit = !(boot_p && boot_hit);
        OP_SEC_SET: next_permit = 1'b1;
        default: next_permit = 1'b0; // chip erase not offered to firmware
      endcase
    end else begin
      case (op)
        OP_CHIP_ERASE: next_permit = !chip_p && !boot_p;
        OP_BLOCK_ERASE: next_permit = !chip_p && !blk_p && !wr_p && !(boot_p && boot_hit);
        OP_WRITE: next_permit = !wr_p && !(boot_p && boot_hit);
        OP_SEC_SET: next_permit = 1'b1;
        default: next_permit = 1'b0;
      endcase
    end
  end

  // result register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      result_valid <= 1'b0;
      permit <= 1'b0;
    end else begin
      result_valid <= check_valid;
      permit <= check_valid && next_permit;
    end
  end
endmodule // sec_permit_check

// ---- hw/flash_security_gate.sv ----
// flash security gate: screens external and self-programming flash requests
// assumes synchronous inputs, a flash array that accepts each op pulse,
// and an external command engine that issues one command at a time
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - external mode, chip-erase ban: refuse chip and block erase, allow writes.
// - external mode, block-erase ban only: refuse block erase, allow others.
// - external mode, write ban: refuse writes and block erase, allow chip erase.
// - external mode, boot ban: refuse chip erase and boot cluster 0 erase or write.
// - boot cluster 0 spans addresses 0000h to 0fffh.
// - self-programming ignores chip, block and write bans.
// - self-programming with boot ban refuses boot cluster 0 erase and write.
// - chip-erase and boot bans, once set, never clear.
// - block and write bans clear only on external chip erase.
// - both programmer and firmware set bans; each ban is its own flag.
// - new bans take effect from the next programming mode entry.
// - any unmasked pending interrupt request stops a running self-programming operation.
// - unmasked requests stop it even with interrupts disabled; firmware masks them.
// - after a stop, a new start in self-programming resumes the interrupted operation.
// - self-programming is refused while the cpu runs on the subsystem clock.
// - self-programming forces the high-speed oscillator on despite its stop flag.
// - stop mode does not halt the high-speed oscillator during self-programming.
module flash_security_gate
  import flash_security_pkg::*;
#(
  parameter int OP_CYCLES = SP_OP_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external programmer command path
  input wire logic ext_prog_mode,
  input wire logic ext_cmd_valid,
  input wire flash_op_t ext_cmd_op,
  input wire logic [15:0] ext_cmd_addr,
  input wire logic [3:0] ext_sec_data,
  output logic ext_resp_valid,
  output logic ext_resp_ack,
  // cpu environment
  input wire logic cpu_on_subclock,
  input wire logic flash_mode_pin,
  input wire logic [31:0] irq_request_flags,
  input wire logic [31:0] irq_mask_flags,
  input wire logic [7:0] osc_mode_register,
  input wire logic stop_mode,
  // flash array and oscillator control
  output logic flash_op_valid,
  output flash_op_t flash_op,
  output logic [15:0] flash_op_addr,
  output logic hs_osc_enable
);
  localparam int CW = $clog2(OP_CYCLES + 1);
  localparam logic [CW-1:0] OP_LOAD = CW'(OP_CYCLES);

  logic [3:0] sec_stored, sec_active;
  logic sp_enable, sp_active, ext_prev;
  logic st_ok, st_refused, st_suspended, st_subclk;
  sp_state_t sp_state;
  logic [CW-1:0] sp_count;
  flash_op_t sp_op;
  logic [15:0] sp_addr;
  logic bus_req, wr_en, start_wr, enable_wr, irq_stop, ext_entry, sp_entry;
  logic chk_valid, chk_self, res_valid, res_permit, ext_pending, sec_set_sp, ext_granted;
  flash_op_t chk_op, chk_op_hold;
  logic [15:0] chk_addr, chk_addr_hold;
  logic [3:0] chk_data;

  assign bus_req = avs_read || avs_write;
  assign wr_en = avs_write && !avs_waitrequest;
  assign enable_wr = wr_en && (avs_address == SP_CTRL_OFS);
  assign start_wr = enable_wr && avs_writedata[CTRL_START_BIT];
  assign irq_stop = |(irq_request_flags & ~irq_mask_flags);
  assign ext_entry = ext_prog_mode && !ext_prev;
  assign sp_entry = enable_wr && avs_writedata[CTRL_ENABLE_BIT] && !sp_enable
                    && !cpu_on_subclock;
  assign sec_set_sp = wr_en && (avs_address == SEC_STORED_OFS) && sp_active;
  assign ext_granted = res_valid && ext_pending && res_permit; // external check that passed

  // one wait cycle per access, then the answer stands for a single edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // read data latched during the wait cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        SP_CTRL_OFS: avs_readdata <= {31'h0, sp_enable};
        SP_CMD_OFS: avs_readdata <= {14'h0, sp_op, sp_addr};
        SP_STATUS_OFS: avs_readdata <= {26'h0, st_subclk, sp_active, st_suspended,
                                        st_refused, st_ok, sp_state != SP_IDLE};
        SEC_STORED_OFS: avs_readdata <= {28'h0, sec_stored};
        SEC_ACTIVE_OFS: avs_readdata <= {28'h0, sec_active};
        default: avs_readdata <= 32'h0; // unmapped reads as zero
      endcase
    end
  end

  // operation and address for the next firmware request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sp_op <= OP_BLOCK_ERASE;
      sp_addr <= 16'h0;
    end else if (wr_en && avs_address == SP_CMD_OFS && sp_state == SP_IDLE) begin
      sp_op <= flash_op_t'(avs_writedata[CMD_OP_LSB +: 2]);
      sp_addr <= avs_writedata[15:0];
    end
  end

  // self-programming mode entry and exit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sp_enable <= 1'b0;
      sp_active <= 1'b0;
      st_subclk <= 1'b0;
    end else begin
      if (enable_wr) begin
        sp_enable <= avs_writedata[CTRL_ENABLE_BIT];
      end
      if (enable_wr && avs_writedata[CTRL_ENABLE_BIT] && cpu_on_subclock) begin
        st_subclk <= 1'b1;
      end else if (enable_wr) begin
        st_subclk <= 1'b0;
      end
      if (sp_entry) begin
        sp_active <= 1'b1;
      end else if ((enable_wr && !avs_writedata[CTRL_ENABLE_BIT]) || cpu_on_subclock) begin
        sp_active <= 1'b0;
      end
    end
  end

  // external mode entry detection
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_prog_mode;
    end
  end

  // stored flags: set-only for chip and boot bans, block and write cleared by chip erase
  // uses the held op: the live mux already shows the next command by the result cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sec_stored <= SEC_RESET;
    end else begin
      if (ext_granted && chk_op_hold == OP_SEC_SET) begin
        sec_stored <= sec_stored | chk_data | (sec_set_sp ? avs_writedata[3:0] : 4'h0);
      end else if (sec_set_sp) begin
        sec_stored <= sec_stored | avs_writedata[3:0];
      end else if (ext_granted && chk_op_hold == OP_CHIP_ERASE) begin
        sec_stored[SEC_BLOCK_BIT] <= 1'b0;
        sec_stored[SEC_WRITE_BIT] <= 1'b0;
      end
    end
  end

  // session flags copied only at a mode entry
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sec_active <= SEC_RESET;
    end else if (ext_entry || sp_entry) begin
      sec_active <= sec_stored;
    end
  end

  // permission checker shared by both paths; external commands win a tie
  always_comb begin
    chk_valid = 1'b0;
    chk_self = 1'b0;
    chk_op = ext_cmd_op;
    chk_addr = ext_cmd_addr;
    if (ext_cmd_valid && ext_prog_mode && !ext_pending) begin
      chk_valid = 1'b1;
    end else if (sp_state == SP_IDLE && start_wr && sp_active && !st_suspended) begin
      chk_valid = 1'b1;
      chk_self = 1'b1;
      chk_op = sp_op;
      chk_addr = sp_addr;
    end
  end

  sec_permit_check u_check (
    .core_clk(core_clk),
    .reset(reset),
    .check_valid(chk_valid),
    .self_mode(chk_self),
    .op(chk_op),
    .addr(chk_addr),
    .flags(sec_active),
    .result_valid(res_valid),
    .permit(res_permit)
  );

  // remember what went into the checker
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_pending <= 1'b0;
      chk_data <= 4'h0;
    end else begin
      ext_pending <= chk_valid && !chk_self;
      if (chk_valid) begin
        chk_data <= ext_sec_data;
      end
    end
  end

  // external response: ack on permit, nak on refusal or outside external mode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_resp_valid <= 1'b0;
      ext_resp_ack <= 1'b0;
    end else begin
      ext_resp_valid <= (res_valid && ext_pending) || (ext_cmd_valid && !ext_prog_mode);
      ext_resp_ack <= res_valid && ext_pending && res_permit;
    end
  end

  // self-programming sequencer with interrupt stop and resume
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sp_state <= SP_IDLE;
      sp_count <= '0;
    end else begin
      case (sp_state)
        SP_IDLE: begin
          if (start_wr && sp_active && !st_suspended && !chk_valid) begin
            sp_state <= SP_IDLE; // never taken: this start always raises chk_valid
          end else if (start_wr && sp_active && st_suspended) begin
            sp_state <= SP_RUN;
          end else if (chk_valid && chk_self) begin
            sp_state <= SP_CHECK;
          end
        end
        SP_CHECK: begin
          if (res_permit && sp_op != OP_SEC_SET) begin
            sp_state <= SP_RUN;
            sp_count <= OP_LOAD;
          end else begin
            sp_state <= SP_IDLE;
          end
        end
        SP_RUN: begin
          if (irq_stop || !sp_active) begin
            sp_state <= SP_IDLE;
          end else if (sp_count == CW'(1)) begin
            sp_state <= SP_IDLE;
            sp_count <= '0;
          end else begin
            sp_count <= sp_count - CW'(1);
          end
        end
        default: sp_state <= SP_IDLE;
      endcase
    end
  end

  // status flags; a new start clears them but a same-cycle event wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_ok <= 1'b0;
      st_refused <= 1'b0;
      st_suspended <= 1'b0;
    end else begin
      if (sp_state == SP_CHECK && res_permit && sp_op == OP_SEC_SET) begin
        st_ok <= 1'b1;
      end else if (sp_state == SP_RUN && !irq_stop && sp_active && sp_count == CW'(1)) begin
        st_ok <= 1'b1;
      end else if (start_wr) begin
        st_ok <= 1'b0;
      end
      if (sp_state == SP_CHECK && !res_permit) begin
        st_refused <= 1'b1;
      end else if (start_wr) begin
        st_refused <= 1'b0;
      end
      if (sp_state == SP_RUN && (irq_stop || !sp_active)) begin
        st_suspended <= 1'b1;
      end else if (start_wr && sp_active) begin
        st_suspended <= 1'b0;
      end
    end
  end

  // flash array pulse: external on permit, firmware on completion
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flash_op_valid <= 1'b0;
      flash_op <= OP_CHIP_ERASE;
      flash_op_addr <= 16'h0;
    end else begin
      flash_op_valid <= 1'b0;
      if (res_valid && ext_pending && res_permit && chk_op_hold != OP_SEC_SET) begin
        flash_op_valid <= 1'b1;
        flash_op <= chk_op_hold;
        flash_op_addr <= chk_addr_hold;
      end else if (sp_state == SP_RUN && !irq_stop && sp_active && sp_count == CW'(1)) begin
        flash_op_valid <= 1'b1;
        flash_op <= sp_op;
        flash_op_addr <= sp_addr;
      end
    end
  end

  // copy of the checked external request for the array pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chk_op_hold <= OP_CHIP_ERASE;
      chk_addr_hold <= 16'h0;
    end else if (chk_valid) begin
      chk_op_hold <= chk_op;
      chk_addr_hold <= chk_addr;
    end
  end

  // oscillator forced on in self-programming, stop flag and stop mode ignored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hs_osc_enable <= 1'b1;
    end else begin
      hs_osc_enable <= sp_active || (!osc_mode_register[HS_OSC_STOP_BIT] && !stop_mode);
    end
  end

  // checks
  AST_NO_OP_WHEN_REFUSED: assert property (@(posedge core_clk) disable iff (reset)
    res_valid && !res_permit |=> !flash_op_valid)
    else $error("flash op issued after refusal");
  AST_CHIP_BAN_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    sec_stored[SEC_CHIP_BIT] |=> sec_stored[SEC_CHIP_BIT])
    else $error("chip erase ban cleared");
  AST_BOOT_BAN_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    sec_stored[SEC_BOOT_BIT] |=> sec_stored[SEC_BOOT_BIT])
    else $error("boot ban cleared");
  AST_BAN_CLEAR_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
    $fell(sec_stored[SEC_WRITE_BIT]) |-> $past(ext_granted
      && chk_op_hold == OP_CHIP_ERASE))
    else $error("write ban cleared without chip erase");
  AST_ACTIVE_ONLY_AT_ENTRY: assert property (@(posedge core_clk) disable iff (reset)
    !$stable(sec_active) |-> $past(ext_entry || sp_entry))
    else $error("session flags changed mid-session");
  AST_IRQ_STOPS_RUN: assert property (@(posedge core_clk) disable iff (reset)
    sp_state == SP_RUN && irq_stop |=> sp_state == SP_IDLE && st_suspended)
    else $error("interrupt did not stop self-programming");
  AST_NO_SP_ON_SUBCLK: assert property (@(posedge core_clk) disable iff (reset)
    cpu_on_subclock |=> !sp_active)
    else $error("self-programming active on subsystem clock");
  AST_OSC_FORCED: assert property (@(posedge core_clk) disable iff (reset)
    sp_active |=> hs_osc_enable)
    else $error("oscillator stopped in self-programming");
  AST_EXT_BOOT_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    chk_valid && !chk_self && chk_op == OP_WRITE && sec_active[SEC_BOOT_BIT]
      && chk_addr <= BOOT0_LAST |=> ##1 ext_resp_valid && !ext_resp_ack)
    else $error("boot cluster write accepted");
  AST_BUS_ONE_WAIT: assert property (@(posedge core_clk) disable iff (reset)
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  COV_EXT_ACK: cover property (@(posedge core_clk) ext_resp_valid && ext_resp_ack);
  COV_SP_DONE: cover property (@(posedge core_clk) sp_state == SP_RUN ##1 st_ok);
  COV_SP_RESUME: cover property (@(posedge core_clk) st_suspended ##[1:50] sp_state == SP_RUN);
endmodule // flash_security_gate

// ---- tb/ext_programmer.sv ----
// ext_programmer: far-side programmer model, one command at a time
// assumes the bench waits for done before raising go again
`timescale 1ns/1ps
module ext_programmer
  import flash_security_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bench request
  input wire logic go,
  input wire flash_op_t op_in,
  input wire logic [15:0] addr_in,
  input wire logic [3:0] sec_in,
  output logic done,
  output logic acked,
  // gate command port
  output logic ext_cmd_valid,
  output flash_op_t ext_cmd_op,
  output logic [15:0] ext_cmd_addr,
  output logic [3:0] ext_sec_data,
  input wire logic ext_resp_valid,
  input wire logic ext_resp_ack,
  output logic flash_mode_pin
);
  // board holds the mode pin high all the time
  assign flash_mode_pin = 1'b1;
  // command fields scramble once valid drops, so stale values never pass
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_cmd_valid <= 1'b0;
      ext_cmd_op <= OP_WRITE;
      ext_cmd_addr <= 16'h0000;
      ext_sec_data <= 4'h0;
    end else begin
      ext_cmd_valid <= go;
      ext_cmd_op <= go ? op_in : flash_op_t'(~ext_cmd_op);
      ext_cmd_addr <= go ? addr_in : ~ext_cmd_addr;
      ext_sec_data <= go ? sec_in : ~ext_sec_data;
    end
  end
  // response capture, done one cycle after the answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
      acked <= 1'b0;
    end else begin
      done <= ext_resp_valid;
      if (ext_resp_valid) begin
        acked <= ext_resp_ack;
      end
    end
  end
endmodule // ext_programmer

// ---- tb/tb_flash_security_gate.sv ----
// tb_flash_security_gate: directed tests of ban table, self-programming, irq stop
// assumes the gate's one-wait avalon slave and OP_CYCLES shortened to 8
`timescale 1ns/1ps
module tb_flash_security_gate;
  import flash_security_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_prog_mode = 1'b0;
  logic go = 1'b0;
  flash_op_t op_in = OP_WRITE;
  logic [15:0] addr_in = 16'h0;
  logic [3:0] sec_in = 4'h0;
  logic done, acked, ext_cmd_valid, ext_resp_valid, ext_resp_ack, flash_mode_pin;
  flash_op_t ext_cmd_op, flash_op;
  logic [15:0] ext_cmd_addr, flash_op_addr;
  logic [3:0] ext_sec_data;
  logic cpu_on_subclock = 1'b0;
  logic [31:0] irq_request_flags = 32'h0;
  logic [31:0] irq_mask_flags = 32'h0;
  logic [7:0] osc_mode_register = 8'h00;
  logic stop_mode = 1'b0;
  logic flash_op_valid, hs_osc_enable;
  int miscompares = 0;
  int comparisons = 0;
  int nops = 0;
  logic [31:0] q, last_op;
  always #5 core_clk = ~core_clk;
  flash_security_gate #(.OP_CYCLES(8)) u_flash_security_gate (.core_clk(core_clk),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_prog_mode(ext_prog_mode),
    .ext_cmd_valid(ext_cmd_valid), .ext_cmd_op(ext_cmd_op), .ext_cmd_addr(ext_cmd_addr),
    .ext_sec_data(ext_sec_data), .ext_resp_valid(ext_resp_valid),
    .ext_resp_ack(ext_resp_ack), .cpu_on_subclock(cpu_on_subclock),
    .flash_mode_pin(flash_mode_pin), .irq_request_flags(irq_request_flags),
    .irq_mask_flags(irq_mask_flags), .osc_mode_register(osc_mode_register),
    .stop_mode(stop_mode), .flash_op_valid(flash_op_valid), .flash_op(flash_op),
    .flash_op_addr(flash_op_addr), .hs_osc_enable(hs_osc_enable));
  ext_programmer u_ext_programmer (.core_clk(core_clk), .reset(reset), .go(go),
    .op_in(op_in), .addr_in(addr_in), .sec_in(sec_in), .done(done), .acked(acked),
    .ext_cmd_valid(ext_cmd_valid), .ext_cmd_op(ext_cmd_op), .ext_cmd_addr(ext_cmd_addr),
    .ext_sec_data(ext_sec_data), .ext_resp_valid(ext_resp_valid),
    .ext_resp_ack(ext_resp_ack), .flash_mode_pin(flash_mode_pin));
  // count array pulses; refused requests must leave this untouched
  always @(posedge core_clk) begin
    if (flash_op_valid === 1'b1) begin
      nops++;
      last_op = {14'h0, flash_op, flash_op_addr};
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // mode entry edge reloads the session bans
  task automatic enter();
    ext_prog_mode <= 1'b0;
    repeat (2) @(posedge core_clk);
    ext_prog_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic ext(input flash_op_t op, input logic [15:0] a, input logic [3:0] s,
                     input logic ok);
    int n0;
    n0 = nops;
    @(posedge core_clk);
    go <= 1'b1;
    op_in <= op;
    addr_in <= a;
    sec_in <= s;
    @(posedge core_clk);
    go <= 1'b0;
    do @(posedge core_clk); while (done !== 1'b1);
    chk(acked, ok);
    chk(32'(nops - n0), ok && op != OP_SEC_SET);
    if (ok && op != OP_SEC_SET) chk(last_op, {14'h0, op, a});
  endtask
  // firmware op; exp is {suspended, refused, ok}
  task automatic sp(input flash_op_t op, input logic [15:0] a, input logic ld,
                    input logic [31:0] irq, input logic [2:0] exp);
    int n0;
    n0 = nops;
    if (ld) bus(1'b1, SP_CMD_OFS, {14'h0, op, a});
    bus(1'b1, SP_CTRL_OFS, 32'h3);
    if (irq != 0) begin
      repeat (3) @(posedge core_clk);
      irq_request_flags <= irq;
    end
    do bus(1'b0, SP_STATUS_OFS, 32'h0); while (q[ST_BUSY_BIT] !== 1'b0);
    chk(q[3:1], exp);
    chk(32'(nops - n0), exp == 3'b001 && op != OP_SEC_SET);
    if (exp == 3'b001 && op != OP_SEC_SET) chk(last_op, {14'h0, op, a});
    irq_request_flags <= 32'h0;
  endtask
  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(SEC_STORED_OFS, 32'h0);
    rdchk(SEC_ACTIVE_OFS, 32'h0);
    rdchk(5'h14, 32'h0);
    $display("test reset done");
    enter();
    ext(OP_WRITE, 16'h0800, 4'h0, 1'b1);
    ext(OP_SEC_SET, 16'h0, 4'h2, 1'b1);
    ext(OP_BLOCK_ERASE, 16'h1000, 4'h0, 1'b1);
    enter();
    ext(OP_BLOCK_ERASE, 16'h1000, 4'h0, 1'b0);
    ext(OP_WRITE, 16'h1000, 4'h0, 1'b1);
    ext(OP_CHIP_ERASE, 16'h0, 4'h0, 1'b1);
    rdchk(SEC_STORED_OFS, 32'h0);
    enter();
    ext(OP_BLOCK_ERASE, 16'h1000, 4'h0, 1'b1);
    ext(OP_SEC_SET, 16'h0, 4'h4, 1'b1);
    enter();
    ext(OP_WRITE, 16'h1000, 4'h0, 1'b0);
    ext(OP_BLOCK_ERASE, 16'h1000, 4'h0, 1'b0);
    ext(OP_CHIP_ERASE, 16'h0, 4'h0, 1'b1);
    ext(OP_SEC_SET, 16'h0, 4'h8, 1'b1);
    enter();
    ext(OP_CHIP_ERASE, 16'h0, 4'h0, 1'b0);
    ext(OP_WRITE, BOOT0_LAST, 4'h0, 1'b0);
    ext(OP_WRITE, 16'h1000, 4'h0, 1'b1);
    ext(OP_BLOCK_ERASE, BOOT0_FIRST, 4'h0, 1'b0);
    ext(OP_SEC_SET, 16'h0, 4'h1, 1'b1);
    enter();
    ext(OP_BLOCK_ERASE, 16'h1000, 4'h0, 1'b0);
    ext(OP_WRITE, 16'h1000, 4'h0, 1'b1);
    rdchk(SEC_STORED_OFS, 32'h9);
    rdchk(SEC_ACTIVE_OFS, 32'h9);
    ext_prog_mode <= 1'b0;
    ext(OP_WRITE, 16'h1000, 4'h0, 1'b0);
    $display("test external done");
    bus(1'b1, SP_CTRL_OFS, 32'h1);
    sp(OP_BLOCK_ERASE, 16'h1000, 1'b1, 32'h0, 3'b001);
    sp(OP_WRITE, 16'h0800, 1'b1, 32'h0, 3'b010);
    sp(OP_CHIP_ERASE, 16'h0, 1'b1, 32'h0, 3'b010);
    bus(1'b1, SEC_STORED_OFS, 32'h4);
    rdchk(SEC_STORED_OFS, 32'hd);
    sp(OP_SEC_SET, 16'h0, 1'b1, 32'h0, 3'b001);
    rdchk(SEC_STORED_OFS, 32'hd);
    $display("test self done");
    sp(OP_WRITE, 16'h2000, 1'b1, 32'h80000000, 3'b100);
    sp(OP_WRITE, 16'h2000, 1'b0, 32'h0, 3'b001);
    irq_mask_flags <= 32'h1;
    sp(OP_WRITE, 16'h2000, 1'b1, 32'h1, 3'b001);
    irq_mask_flags <= 32'h0;
    $display("test irq done");
    osc_mode_register <= 8'h01;
    stop_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(hs_osc_enable, 1'b1);
    bus(1'b1, SP_CTRL_OFS, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(hs_osc_enable, 1'b0);
    cpu_on_subclock <= 1'b1;
    bus(1'b1, SP_CTRL_OFS, 32'h1);
    bus(1'b0, SP_STATUS_OFS, 32'h0);
    chk(q[5:4], 2'b10);
    $display("test clock done");
    conclude();
  end
endmodule // tb_flash_security_gate
